// file: design/tcc_pkg.sv
// shared constants and types of the timer capture/compare block
package tcc_pkg;
    localparam int ADDR_W = 8;

    localparam logic [7:0] OFS_CTRL_ONE  = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO  = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_CAP1_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CAP1_LOW  = 8'h10;
    localparam logic [7:0] OFS_CMP1_HIGH = 8'h14;
    localparam logic [7:0] OFS_CMP1_LOW  = 8'h18;
    localparam logic [7:0] OFS_CAP2_HIGH = 8'h1C;
    localparam logic [7:0] OFS_CAP2_LOW  = 8'h20;
    localparam logic [7:0] OFS_CMP2_HIGH = 8'h24;
    localparam logic [7:0] OFS_CMP2_LOW  = 8'h28;
    localparam logic [7:0] OFS_CNT_HIGH  = 8'h2C;
    localparam logic [7:0] OFS_CNT_LOW   = 8'h30;

    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [15:0] CNT_RESET = 16'hFFFC;
    localparam logic [15:0] CAP_RESET = 16'h0000;
    localparam logic [7:0]  CTL_RESET = 8'h00;

    // status bit positions
    localparam int ST_CAP1   = 7;
    localparam int ST_MATCH1 = 6;
    localparam int ST_CAP2   = 4;
    localparam int ST_MATCH2 = 3;

    localparam logic [1:0] TICK_DIV2 = 2'h0;
    localparam logic [1:0] TICK_DIV4 = 2'h1;
    localparam logic [1:0] TICK_DIV8 = 2'h2;
    localparam logic [1:0] TICK_EXT  = 2'h3;

    localparam logic [2:0] PRE_MASK_DIV2 = 3'h1;
    localparam logic [2:0] PRE_MASK_DIV4 = 3'h3;
    localparam logic [2:0] PRE_MASK_DIV8 = 3'h7;

    typedef struct packed {
        logic capture_irq_enable;
        logic match_irq_enable;
        logic spare;
        logic force_level_bit2;
        logic force_level_bit1;
        logic output_level_bit2;
        logic capture_edge_select1;
        logic output_level_bit1;
    } tcc_ctrl_one_s;

    typedef struct packed {
        logic       compare_pin_enable1;
        logic       compare_pin_enable2;
        logic       one_pulse_select;
        logic       pwm_select;
        logic [1:0] tick_select;
        logic       capture_edge_select2;
        logic       ext_edge_select;
    } tcc_ctrl_two_s;
endpackage

// file: design/tcc_timer.sv
// capture/compare channels of a 16-bit free-running timer behind an APB slave
// What this block does
// - an active edge on a capture pin copies the 16-bit counter into its register
// - capture registers are read-only; writes leave them unchanged
// - edge select bit per channel: channel 1 in control one, channel 2 in control two
// - a capture sets its flag; interrupt when enabled and cpu mask clear
// - one capture interrupt enable covers both capture channels
// - capture flag clears after status read seeing it, then capture low access
// - after capture high read, captures are blocked until capture low is read
// - each new capture overwrites the previous value
// - in one-pulse or pwm mode only capture channel 2 captures normally
// - capture pins are watched always, whatever the pin direction
// - reduced variant: no capture 2, compare 2 write-only, both channel 2 flags zero
// - compare registers checked each tick; match sets flag except in pwm mode and for compare 1 in one-pulse mode, maskable interrupt
// - compare registers read/write, untouched by hardware, reset to 8000h
// - on match with pin enable the pin takes its level bit, pin 2 only outside one-pulse and pwm mode; latch low in reset
// - match flag clears after status read seeing it, then compare low access
// - writing compare high suspends the channel until compare low is written
// - with pin enable clear no level is driven; flag and interrupt still work
// - div2 tick matches at counter one below compare; slower ticks at counter equal
// - force bit copies level bit to pin at once, no flag, no interrupt
// - force bits do nothing in one-pulse or pwm mode
// - one-pulse select in control two takes over capture 1 and compare 1
// - tick select picks cpu clock over 2, 4 or 8, or the external tick
// - counter restarts from FFFCh on reset and on a counter low write
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps

module tcc_timer #(
    parameter bit REDUCED_CH2 = 1'b0
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tcc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [1:0]                 capture_input_pin,
    input  wire logic                       external_tick_pin,
    input  wire logic                       cpu_irq_mask,
    output logic                            timer_irq,
    output logic [1:0]                      compare_output_pin,
    output logic [1:0]                      compare_output_pin_oe
);
    import tcc_pkg::*;

    tcc_ctrl_one_s ctrl_one;
    tcc_ctrl_two_s ctrl_two;

    logic [1:0]  cap_meta;
    logic [1:0]  cap_sync;
    logic [1:0]  cap_prev;
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_prev;
    logic [15:0] cnt;
    logic [2:0]  pre;
    logic [15:0] capture_value [2];
    logic [15:0] compare_value [2];
    logic [1:0]  capture_flag;
    logic [1:0]  match_flag;
    logic [1:0]  cap_arm;
    logic [1:0]  match_arm;
    logic [1:0]  cap_lock;
    logic [1:0]  cmp_hold;
    logic [1:0]  pin;

    logic        setup;
    logic        rd;
    logic        wr;
    logic        tick;
    logic [2:0]  pre_mask;
    logic        pwm_on;
    logic        opm_on;
    logic        opm_start;
    logic [1:0]  edge_sel;
    logic [1:0]  cap_edge;
    logic [1:0]  match;
    logic [1:0]  cap_set;
    logic [1:0]  match_set;
    logic [1:0]  cap_clr;
    logic [1:0]  match_clr;
    logic [1:0]  cap_low_acc;
    logic [1:0]  cmp_low_acc;
    logic [1:0]  cap_high_rd;
    logic [1:0]  cmp_high_wr;
    logic [1:0]  cmp_low_wr;
    logic        cnt_low_wr;
    logic        force_wr;
    logic [7:0]  next_rdata;
    logic        addr_ok;

    assign setup  = psel & ~penable;
    assign rd     = psel & penable & ~pwrite;
    assign wr     = psel & penable & pwrite;
    assign pready = 1'b1;

    // pins from outside pass two flip-flops before use
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_meta <= 2'h0;
            cap_sync <= 2'h0;
            cap_prev <= 2'h0;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            cap_meta <= capture_input_pin;
            cap_sync <= cap_meta;
            cap_prev <= cap_sync;
            ext_meta <= external_tick_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // access decode
    assign cap_low_acc[0] = psel & penable & (paddr == OFS_CAP1_LOW);
    assign cap_low_acc[1] = psel & penable & (paddr == OFS_CAP2_LOW);
    assign cmp_low_acc[0] = psel & penable & (paddr == OFS_CMP1_LOW);
    assign cmp_low_acc[1] = psel & penable & (paddr == OFS_CMP2_LOW);
    assign cap_high_rd[0] = rd & (paddr == OFS_CAP1_HIGH);
    assign cap_high_rd[1] = rd & (paddr == OFS_CAP2_HIGH) & ~REDUCED_CH2;
    assign cmp_high_wr[0] = wr & (paddr == OFS_CMP1_HIGH);
    assign cmp_high_wr[1] = wr & (paddr == OFS_CMP2_HIGH);
    assign cmp_low_wr     = cmp_low_acc & {2{pwrite}};
    assign cnt_low_wr     = wr & (paddr == OFS_CNT_LOW);
    assign force_wr       = wr & (paddr == OFS_CTRL_ONE);

    // control registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one <= tcc_ctrl_one_s'(CTL_RESET);
            ctrl_two <= tcc_ctrl_two_s'(CTL_RESET);
        end else begin
            if (force_wr) begin
                ctrl_one <= tcc_ctrl_one_s'(pwdata[7:0]);
            end
            if (wr && paddr == OFS_CTRL_TWO) begin
                ctrl_two <= tcc_ctrl_two_s'(pwdata[7:0]);
            end
        end
    end

    assign pwm_on   = ctrl_two.pwm_select;
    assign opm_on   = ctrl_two.one_pulse_select & ~ctrl_two.pwm_select;
    assign edge_sel = {ctrl_two.capture_edge_select2, ctrl_one.capture_edge_select1};

    // timer tick from the prescaler or the external pin
    always_comb begin
        case (ctrl_two.tick_select)
            TICK_DIV2: pre_mask = PRE_MASK_DIV2;
            TICK_DIV4: pre_mask = PRE_MASK_DIV4;
            TICK_DIV8: pre_mask = PRE_MASK_DIV8;
            default:   pre_mask = PRE_MASK_DIV8;
        endcase
        if (ctrl_two.tick_select == TICK_EXT) begin
            tick = (ext_sync != ext_prev) && (ext_sync == ctrl_two.ext_edge_select);
        end else begin
            tick = (pre & pre_mask) == pre_mask;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre <= 3'h0;
        end else begin
            pre <= pre + 3'h1;
        end
    end

    // capture edges are seen whatever the pin direction
    assign cap_edge  = (cap_sync ^ cap_prev) & ~(cap_sync ^ edge_sel);
    assign opm_start = cap_edge[0] & opm_on;

    // compare match timing depends on tick rate
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (ctrl_two.tick_select == TICK_DIV2) begin
                match[i] = tick & ~cmp_hold[i] & (16'(cnt + 16'h1) == compare_value[i]);
            end else begin
                match[i] = tick & ~cmp_hold[i] & (cnt == compare_value[i]);
            end
        end
    end

    // free-running counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= CNT_RESET;
        end else if (cnt_low_wr || opm_start || (pwm_on && match[1])) begin
            cnt <= CNT_RESET;
        end else if (tick) begin
            cnt <= cnt + 16'h1;
        end
    end

    // flag set and clear terms
    assign cap_set[0]   = (cap_edge[0] & ~cap_lock[0] & ~opm_on & ~pwm_on)
                          | opm_start | (pwm_on & match[1]);
    assign cap_set[1]   = cap_edge[1] & ~cap_lock[1] & ~REDUCED_CH2;
    assign match_set[0] = match[0] & ~opm_on & ~pwm_on;
    assign match_set[1] = match[1] & ~pwm_on & ~REDUCED_CH2;
    assign cap_clr      = cap_arm & cap_low_acc;
    assign match_clr    = match_arm & cmp_low_acc;

    // capture registers, loaded only by hardware
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            capture_value[0] <= CAP_RESET;
            capture_value[1] <= CAP_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_set[i]) begin
                    capture_value[i] <= cnt;
                end
            end
        end
    end

    // high byte read locks capture until the low byte read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_lock <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_high_rd[i]) begin
                    cap_lock[i] <= 1'b1;
                end else if (cap_low_acc[i] && !pwrite) begin
                    cap_lock[i] <= 1'b0;
                end
            end
        end
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            capture_flag <= 2'h0;
            match_flag   <= 2'h0;
        end else begin
            capture_flag <= cap_set | (capture_flag & ~cap_clr);
            match_flag   <= match_set | (match_flag & ~match_clr);
        end
    end

    // armed latches for the two-step clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_arm   <= 2'h0;
            match_arm <= 2'h0;
        end else begin
            if (rd && paddr == OFS_STATUS) begin
                cap_arm   <= cap_arm | {prdata[ST_CAP2], prdata[ST_CAP1]};
                match_arm <= match_arm | {prdata[ST_MATCH2], prdata[ST_MATCH1]};
            end else begin
                cap_arm   <= cap_arm & ~cap_low_acc;
                match_arm <= match_arm & ~cmp_low_acc;
            end
        end
    end

    // compare registers, written only by software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            compare_value[0] <= CMP_RESET;
            compare_value[1] <= CMP_RESET;
            cmp_hold         <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cmp_high_wr[i]) begin
                    compare_value[i][15:8] <= pwdata[7:0];
                    cmp_hold[i]            <= 1'b1;
                end else if (cmp_low_wr[i]) begin
                    compare_value[i][7:0] <= pwdata[7:0];
                    cmp_hold[i]           <= 1'b0;
                end
            end
        end
    end

    // compare pin latches
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin <= 2'h0;
        end else begin
            if (opm_start || (pwm_on && match[1])) begin
                pin[0] <= ctrl_one.output_level_bit2;
            end else if (match[0] && ctrl_two.compare_pin_enable1) begin
                pin[0] <= ctrl_one.output_level_bit1;
            end else if (force_wr && pwdata[3] && !opm_on && !pwm_on) begin
                pin[0] <= pwdata[0];
            end
            if (match[1] && ctrl_two.compare_pin_enable2 && !opm_on && !pwm_on) begin
                pin[1] <= ctrl_one.output_level_bit2;
            end else if (force_wr && pwdata[4] && !opm_on && !pwm_on) begin
                pin[1] <= pwdata[2];
            end
        end
    end

    assign compare_output_pin    = pin;
    assign compare_output_pin_oe = {ctrl_two.compare_pin_enable2, ctrl_two.compare_pin_enable1};

    // one timer interrupt gated by the cpu mask
    assign timer_irq = ~cpu_irq_mask & ((ctrl_one.capture_irq_enable & (|capture_flag))
                       | (ctrl_one.match_irq_enable & (|match_flag)));

    // read mux
    always_comb begin
        next_rdata = 8'h00;
        addr_ok    = 1'b1;
        case (paddr)
            OFS_CTRL_ONE:  next_rdata = ctrl_one;
            OFS_CTRL_TWO:  next_rdata = ctrl_two;
            OFS_STATUS: begin
                next_rdata[ST_CAP1]   = capture_flag[0];
                next_rdata[ST_MATCH1] = match_flag[0];
                next_rdata[ST_CAP2]   = capture_flag[1];
                next_rdata[ST_MATCH2] = match_flag[1];
            end
            OFS_CAP1_HIGH: next_rdata = capture_value[0][15:8];
            OFS_CAP1_LOW:  next_rdata = capture_value[0][7:0];
            OFS_CMP1_HIGH: next_rdata = compare_value[0][15:8];
            OFS_CMP1_LOW:  next_rdata = compare_value[0][7:0];
            OFS_CAP2_HIGH: next_rdata = REDUCED_CH2 ? 8'h00 : capture_value[1][15:8];
            OFS_CAP2_LOW:  next_rdata = REDUCED_CH2 ? 8'h00 : capture_value[1][7:0];
            OFS_CMP2_HIGH: next_rdata = REDUCED_CH2 ? 8'h00 : compare_value[1][15:8];
            OFS_CMP2_LOW:  next_rdata = REDUCED_CH2 ? 8'h00 : compare_value[1][7:0];
            OFS_CNT_HIGH:  next_rdata = cnt[15:8];
            OFS_CNT_LOW:   next_rdata = cnt[7:0];
            default:       addr_ok = 1'b0;
        endcase
    end

    // read data is caught in the setup cycle and held through the access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (setup) begin
            prdata <= {24'h0, next_rdata};
        end
    end

    assign pslverr = psel & penable & ~addr_ok;
endmodule

// file: tb/tb_tcc_timer.sv
// self-checking bench of the timer capture/compare block
`timescale 1ns/100ps
module tb_tcc_timer;
    import tcc_pkg::*;
    logic        clk_sys, rst_n, psel, penable, pwrite, cpu_irq_mask, last_err;
    logic        pready, pslverr, timer_irq, external_tick_pin;
    logic [7:0]  paddr, q, d;
    logic [31:0] pwdata, prdata;
    logic [1:0]  cap_req, capture_input_pin, compare_output_pin, compare_output_pin_oe;
    logic [15:0] c0, c1, cap, cap2, tgt;
    logic [7:0]  exp_step [4] = '{8'h20, 8'h10, 8'h08, 8'h04};
    int          n_mismatch, n_tests;

    tcc_timer #(.REDUCED_CH2(1'b0)) tcc_timer_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(capture_input_pin), .external_tick_pin(external_tick_pin), .cpu_irq_mask(cpu_irq_mask),
        .timer_irq(timer_irq), .compare_output_pin(compare_output_pin), .compare_output_pin_oe(compare_output_pin_oe));
    tcc_pin_model tcc_pin_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .cap_req(cap_req),
        .capture_input_pin(capture_input_pin), .external_tick_pin(external_tick_pin));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] expv);
        n_tests++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, expv);
        end
    endtask

    task clocks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one apb transfer; read data lands in q
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata[7:0];
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    task rd16(input logic [7:0] a, output logic [15:0] v);
        apb(1'b0, a, 8'h00);
        v[15:8] = q;
        apb(1'b0, a + 8'h04, 8'h00);
        v[7:0] = q;
    endtask

    task wr16(input logic [7:0] a, input logic [15:0] v);
        apb(1'b1, a, v[15:8]);
        apb(1'b1, a + 8'h04, v[7:0]);
    endtask

    task t_reset_map;
        rd16(OFS_CMP1_HIGH, c0);
        check(c0, CMP_RESET);
        rd16(OFS_CMP2_HIGH, c0);
        check(c0, CMP_RESET);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q, 8'h00);
        apb(1'b0, 8'h34, 8'h00);
        check(last_err, 1'b1);
        check(q, 8'h00);
    endtask

    task t_capture;
        apb(1'b1, OFS_CTRL_ONE, 8'h82);
        rd16(OFS_CNT_HIGH, c0);
        cap_req[0] <= 1'b1;
        clocks(8);
        rd16(OFS_CNT_HIGH, c1);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q[7], 1'b1);
        check(timer_irq, 1'b0);
        cpu_irq_mask <= 1'b0;
        clocks(2);
        check(timer_irq, 1'b1);
        apb(1'b0, OFS_CAP1_HIGH, 8'h00);
        cap[15:8] = q;
        cap_req[0] <= 1'b0;
        clocks(6);
        cap_req[0] <= 1'b1;
        clocks(8);
        apb(1'b0, OFS_CAP1_LOW, 8'h00);
        cap[7:0] = q;
        check(cap >= c0 && cap <= c1, 1'b1);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q[7], 1'b0);
        check(timer_irq, 1'b0);
        cap_req[0] <= 1'b0;
        clocks(6);
        cap_req[0] <= 1'b1;
        clocks(8);
        rd16(OFS_CAP1_HIGH, cap2);
        check(cap2 > cap, 1'b1);
        apb(1'b1, OFS_CAP1_LOW, 8'h55);
        apb(1'b0, OFS_CAP1_LOW, 8'h00);
        check(q, cap2[7:0]);
        cpu_irq_mask <= 1'b1;
        cap_req[1] <= 1'b1;
        clocks(8);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q[4], 1'b0);
        cap_req[1] <= 1'b0;
        clocks(8);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q[4], 1'b1);
    endtask

    task t_compare;
        apb(1'b1, OFS_CTRL_TWO, 8'h80);
        apb(1'b1, OFS_CTRL_ONE, 8'h45);
        cpu_irq_mask <= 1'b0;
        rd16(OFS_CNT_HIGH, c0);
        tgt = c0 + 16'h0028;
        wr16(OFS_CMP1_HIGH, tgt);
        wr16(OFS_CMP2_HIGH, tgt);
        clocks(100);
        check(timer_irq, 1'b1);
        check(compare_output_pin, 2'h1);
        check(compare_output_pin_oe, 2'h1);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q[6], 1'b1);
        check(q[3], 1'b1);
        apb(1'b1, OFS_CMP2_HIGH, tgt[15:8]);
        apb(1'b0, OFS_STATUS, 8'h00);
        apb(1'b1, OFS_CMP2_LOW, tgt[7:0]);
        apb(1'b1, OFS_CMP1_LOW, tgt[7:0]);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q[6], 1'b0);
        check(q[3], 1'b0);
        check(timer_irq, 1'b0);
        rd16(OFS_CNT_HIGH, c0);
        tgt = c0 + 16'h0014;
        wr16(OFS_CMP1_HIGH, tgt);
        apb(1'b1, OFS_CMP1_HIGH, tgt[15:8]);
        clocks(80);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q[6], 1'b0);
        apb(1'b1, OFS_CMP1_LOW, tgt[7:0]);
        rd16(OFS_CMP1_HIGH, c1);
        check(c1, tgt);
    endtask

    task t_force;
        apb(1'b1, OFS_CTRL_ONE, 8'h08);
        clocks(1);
        check(compare_output_pin[0], 1'b0);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(q[6], 1'b0);
        apb(1'b1, OFS_CTRL_TWO, 8'hA0);
        apb(1'b1, OFS_CTRL_ONE, 8'h0D);
        clocks(1);
        check(compare_output_pin[0], 1'b0);
        cap_req[0] <= 1'b0;
        clocks(8);
        check(compare_output_pin[0], 1'b1);
        apb(1'b0, OFS_CNT_HIGH, 8'h00);
        check(q, 8'hFF);
        apb(1'b1, OFS_CTRL_TWO, 8'h00);
    endtask

    task t_tick;
        apb(1'b1, OFS_CNT_LOW, 8'h00);
        apb(1'b0, OFS_CNT_HIGH, 8'h00);
        check(q, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_CTRL_TWO, {4'h0, i[1:0], 2'h1});
            apb(1'b0, OFS_CNT_LOW, 8'h00);
            c0[7:0] = q;
            clocks(61);
            apb(1'b0, OFS_CNT_LOW, 8'h00);
            d = q - c0[7:0];
            check(d, exp_step[i]);
        end
    endtask

    initial begin
        rst_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cap_req = 2'h0;
        cpu_irq_mask = 1'b1;
        n_mismatch = 0;
        n_tests = 0;
        // a clean falling edge so the asynchronous reset acts before the first clock
        #1 rst_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset_map();
        t_capture();
        t_compare();
        t_force();
        t_tick();
        report_and_stop();
    end
endmodule

// file: tb/tcc_pin_model.sv
// external pin model: capture sources and a slow external tick
`timescale 1ns/100ps
module tcc_pin_model (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [1:0]  cap_req,
    output logic [1:0]      capture_input_pin,
    output logic            external_tick_pin
);
    logic [2:0] div;

    // tick period of 16 clocks, well below a quarter of the cpu clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div <= 3'h0;
            external_tick_pin <= 1'b0;
        end else begin
            div <= div + 3'h1;
            if (div == 3'h7) begin
                external_tick_pin <= ~external_tick_pin;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        capture_input_pin <= cap_req;
    end
endmodule

// file: tb/tcc_timer_props.sv
// port checker of the timer capture/compare block
`timescale 1ns/100ps
module tcc_timer_props
    import tcc_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [1:0]        capture_input_pin,
    input wire logic              external_tick_pin,
    input wire logic              cpu_irq_mask,
    input wire logic              timer_irq,
    input wire logic [1:0]        compare_output_pin,
    input wire logic [1:0]        compare_output_pin_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // one-pulse or pwm selected by the last control two write
    logic mode_on;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_on <= 1'b0;
        end else if (psel && penable && pwrite && paddr == OFS_CTRL_TWO) begin
            mode_on <= pwdata[5] | pwdata[4];
        end
    end

    sequence s_wr_ctl2;
        psel && penable && pwrite && paddr == OFS_CTRL_TWO;
    endsequence
    sequence s_force1;
        psel && penable && pwrite && paddr == OFS_CTRL_ONE && pwdata[3];
    endsequence

    a_ready_high: assert property (pready) else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    a_err_mapped: assert property (psel && penable && paddr <= OFS_CNT_LOW && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("pslverr on mapped address");
    a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    a_irq_masked: assert property (cpu_irq_mask |-> !timer_irq) else $error("irq while masked");
    a_irq_after_reset: assert property ($rose(rst_n) |-> !timer_irq ##1 !timer_irq) else $error("irq after reset");
    a_reset_pin_low: assert property (disable iff (1'b0) !rst_n |-> compare_output_pin == 2'h0)
        else $error("pin latch not low in reset");
    a_oe_follow: assert property (s_wr_ctl2 |=> compare_output_pin_oe == {$past(pwdata[6]), $past(pwdata[7])})
        else $error("pin enable not taken");
    a_force_copy: assert property (s_force1 ##0 !mode_on |=> compare_output_pin[0] == $past(pwdata[0]))
        else $error("force level not copied");
    a_force_ignored: assert property (s_force1 ##0 mode_on |=> $stable(compare_output_pin))
        else $error("force acted in pulse mode");
endmodule

bind tcc_timer tcc_timer_props tcc_timer_props_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_input_pin(capture_input_pin),
    .external_tick_pin(external_tick_pin), .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq),
    .compare_output_pin(compare_output_pin), .compare_output_pin_oe(compare_output_pin_oe));
